// File: pkg/txsym_pkg.sv
// Constants, register map and state codes of the transmit symbol generator.
// Assumes a 16-bit register port and a byte-wide frame data stream.
package txsym_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int CFG_W = 12;

  // Register offsets
  localparam logic [3:0] OFS_SYM0 = 4'h0;
  localparam logic [3:0] OFS_SYM1 = 4'h1;
  localparam logic [3:0] OFS_SYM2 = 4'h2;
  localparam logic [3:0] OFS_SYM3 = 4'h3;
  localparam logic [3:0] OFS_LEN_LOW = 4'h4;
  localparam logic [3:0] OFS_LEN_HIGH = 4'h5;
  localparam logic [3:0] OFS_BURST_LEN = 4'h6;
  localparam logic [3:0] OFS_BURST_CTRL = 4'h7;
  localparam logic [3:0] OFS_FRAME_CTRL = 4'h8;
  localparam logic [3:0] OFS_CFG_LOW = 4'h9;
  localparam logic [3:0] OFS_CFG_HIGH = 4'hA;
  localparam logic [3:0] OFS_CONTROL = 4'hB;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // Writable bits of each register
  localparam logic [15:0] MASK_LONG_PAT = 16'hFFFF;
  localparam logic [15:0] MASK_SHORT_PAT = 16'h00FF;
  localparam logic [15:0] MASK_LEN_LOW = 16'h00FF;
  localparam logic [15:0] MASK_LEN_HIGH = 16'h0077;
  localparam logic [15:0] MASK_BURST_CTRL = 16'h000F;
  localparam logic [15:0] MASK_FRAME_CTRL = 16'h00FF;
  localparam logic [15:0] MASK_CFG = 16'h0FFF;

  // Field positions
  localparam int FC_LEAD_LSB = 0;
  localparam int FC_TRAIL_LSB = 2;
  localparam int FC_CODE_LSB = 4;
  localparam int BC_EN0 = 0;
  localparam int BC_VAL0 = 1;
  localparam int BC_EN1 = 2;
  localparam int BC_VAL1 = 3;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_UNDERRUN = 1;
  localparam int STAT_SYMBOL = 2;

  // Reset values and codes
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] CODE_BITGEN = 4'h0;
  localparam logic [1:0] SEL_NONE = 2'h0;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_BURST = 5'b00010,
    ST_PAT = 5'b00100,
    ST_DATA = 5'b01000,
    ST_DRAIN = 5'b10000
  } seq_state_t;

endpackage : txsym_pkg

// File: pkg/byte_stream_if.sv
// Byte stream with valid/ready handshake and an end-of-frame mark.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
  logic valid;
  logic ready;
  logic last;
  logic [7:0] data;
  modport sender (output valid, output last, output data, input ready);
  modport receiver (input valid, input last, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// File: src/two_entry_buffer.sv
// Two-entry elastic buffer for frame data bytes.
// Assumes the consumer drives ready combinationally from valid.
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Filling and draining sides
  byte_stream_if.receiver fillSide,
  byte_stream_if.sender drainSide
);

  logic [8:0] slot_r [2];
  logic wrPtr_r;
  logic rdPtr_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic inReady_r;
  logic push;
  logic pop;

  // Handshakes on both sides
  assign push = fillSide.valid && inReady_r;
  assign pop = drainSide.valid && drainSide.ready;
  assign fillSide.ready = inReady_r;
  assign drainSide.valid = (count_r != 2'h0);
  assign drainSide.data = slot_r[rdPtr_r][7:0];
  assign drainSide.last = slot_r[rdPtr_r][8];

  // Occupancy after this cycle
  always_comb
  begin
    count_nxt = count_r;
    if (push && !pop)
    begin
      count_nxt = 2'(count_r + 2'h1);
    end
    else if (pop && !push)
    begin
      count_nxt = 2'(count_r - 2'h1);
    end
  end

  // Pointers and count; ready is a flop so stalls reach the source
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= 1'b0;
      rdPtr_r <= 1'b0;
      count_r <= 2'h0;
      inReady_r <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr_r <= !wrPtr_r;
      if (pop)
        rdPtr_r <= !rdPtr_r;
      count_r <= count_nxt;
      inReady_r <= (count_nxt != 2'h2);
    end
  end

  // Storage needs no reset
  always_ff @(posedge clock)
  begin
    if (push)
      slot_r[wrPtr_r] <= {fillSide.last, fillSide.data};
  end

endmodule : two_entry_buffer
`default_nettype wire

// File: src/tx_symbol_generator.sv
// Transmit symbol generator: wraps coded frame data in protocol symbols.
// Assumes txBitTick is a one-cycle pulse per transmit bit, synchronous.
//
// Contract
// - Four separately programmed symbols can be placed into a frame.
// - Symbols zero and one hold a pattern of up to sixteen bits.
// - Symbols zero and one may add a burst of up to 256 equal bits.
// - Symbols two and three hold at most eight bits and have no burst.
// - The pattern bit at position zero goes out last, higher ones first.
// - Pattern bits above the programmed length are never sent.
// - The frame control register picks which symbols go with a frame.
// - Only symbol zero, one or two may lead the data.
// - Only symbol one, two or three may trail the data.
// - Symbols zero and one share a config set, two and three another.
// - A config set gives bit rate, subcarrier, pulse and envelope.
// - Data is coded bit by bit only when the coding type is zero.
`timescale 1ns/1ps
`default_nettype none
module tx_symbol_generator
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [15:0] regRdData,
  // Frame data bytes
  input wire logic dataValid,
  input wire logic [7:0] dataByte,
  input wire logic dataLast,
  output logic dataReady,
  // Transmit bit clock
  input wire logic txBitTick,
  // Toward the modulator
  output logic txBit,
  output logic txBitValid,
  output logic txSymbolActive,
  output logic [11:0] txCfg,
  output logic frameBusy
);

  txsym_pkg::seq_state_t state_r;
  logic [15:0] symPat_r [4];
  logic [15:0] lenLow_r;
  logic [15:0] lenHigh_r;
  logic [15:0] burstLen_r;
  logic [15:0] burstCtrl_r;
  logic [15:0] frameCtrl_r;
  logic [15:0] cfgLow_r;
  logic [15:0] cfgHigh_r;
  logic [7:0] cnt_r;
  logic [1:0] symIdx_r;
  logic trailing_r;
  logic haveByte_r;
  logic [7:0] dataSh_r;
  logic [2:0] bitPos_r;
  logic lastByte_r;
  logic underrun_r;
  logic [15:0] regRdData_r;
  logic txBit_r;
  logic txBitValid_r;
  logic txSymbolActive_r;
  logic [11:0] txCfg_r;
  logic frameBusy_r;

  byte_stream_if upIf ();
  byte_stream_if dnIf ();

  logic wrHit;
  logic startReq;
  logic [1:0] leadSel;
  logic [1:0] trailSel;
  logic [3:0] codeType;
  logic [1:0] reqIdx;
  logic reqBurst;
  logic [3:0] reqLen;
  logic [7:0] reqBurstLen;
  txsym_pkg::seq_state_t loadState;
  logic [7:0] loadCnt;
  txsym_pkg::seq_state_t dataState;
  logic [3:0] curLen;
  logic patBit;
  logic burstVal;
  logic [11:0] activeCfg;
  logic pop;
  logic starve;
  logic inSymbol;

  // Incoming bytes pass the two-entry buffer before serialising
  assign upIf.valid = dataValid;
  assign upIf.data = dataByte;
  assign upIf.last = dataLast;
  assign dataReady = upIf.ready;

  two_entry_buffer dataBuf
  (
    .clock(clock),
    .rst_n(rst_n),
    .fillSide(upIf.receiver),
    .drainSide(dnIf.sender)
  );

  // Frame control fields
  assign wrHit = regWrStrobe;
  assign leadSel = frameCtrl_r[txsym_pkg::FC_LEAD_LSB +: 2];
  assign trailSel = frameCtrl_r[txsym_pkg::FC_TRAIL_LSB +: 2];
  assign codeType = frameCtrl_r[txsym_pkg::FC_CODE_LSB +: 4];
  assign startReq = wrHit && (regAddr == txsym_pkg::OFS_CONTROL)
                    && regWrData[txsym_pkg::CTRL_START];

  // Lead codes 1..3 pick symbol 0..2, trail codes 1..3 pick 1..3
  assign reqIdx = (state_r == txsym_pkg::ST_IDLE)
                  ? 2'(leadSel - 2'h1)
                  : trailSel;

  // Length of the symbol being loaded; the short pair has 3-bit fields
  always_comb
  begin
    case (reqIdx)
      2'h0: reqLen = lenLow_r[3:0];
      2'h1: reqLen = lenLow_r[7:4];
      2'h2: reqLen = {1'b0, lenHigh_r[2:0]};
      default: reqLen = {1'b0, lenHigh_r[6:4]};
    endcase
  end

  // Same lookup for the symbol now being sent
  always_comb
  begin
    case (symIdx_r)
      2'h0: curLen = lenLow_r[3:0];
      2'h1: curLen = lenLow_r[7:4];
      2'h2: curLen = {1'b0, lenHigh_r[2:0]};
      default: curLen = {1'b0, lenHigh_r[6:4]};
    endcase
  end

  // Burst exists for the long pair only
  assign reqBurst = !reqIdx[1] && (reqIdx[0]
                    ? burstCtrl_r[txsym_pkg::BC_EN1]
                    : burstCtrl_r[txsym_pkg::BC_EN0]);
  assign reqBurstLen = reqIdx[0] ? burstLen_r[15:8] : burstLen_r[7:0];
  assign loadState = reqBurst ? txsym_pkg::ST_BURST : txsym_pkg::ST_PAT;
  assign loadCnt = reqBurst ? reqBurstLen : {4'h0, reqLen};
  assign dataState = (codeType == txsym_pkg::CODE_BITGEN)
                     ? txsym_pkg::ST_DATA : txsym_pkg::ST_DRAIN;

  // Bit from the pattern, highest used position first
  assign patBit = symPat_r[symIdx_r][cnt_r[3:0]];
  assign burstVal = symIdx_r[0] ? burstCtrl_r[txsym_pkg::BC_VAL1]
                                : burstCtrl_r[txsym_pkg::BC_VAL0];
  assign activeCfg = symIdx_r[1] ? cfgHigh_r[11:0] : cfgLow_r[11:0];
  assign inSymbol = (state_r == txsym_pkg::ST_BURST)
                    || (state_r == txsym_pkg::ST_PAT);

  // Byte fetch: coded data on a tick, dropped data at once
  assign starve = (state_r == txsym_pkg::ST_DATA) && txBitTick
                  && !haveByte_r && !dnIf.valid;
  assign pop = ((state_r == txsym_pkg::ST_DATA) && txBitTick
               && !haveByte_r && dnIf.valid)
               || ((state_r == txsym_pkg::ST_DRAIN) && dnIf.valid);
  assign dnIf.ready = pop;

  // Register writes; a length write completes the symbol definition
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 4; i++)
        symPat_r[i] <= txsym_pkg::RST_WORD;
      lenLow_r <= txsym_pkg::RST_WORD;
      lenHigh_r <= txsym_pkg::RST_WORD;
      burstLen_r <= txsym_pkg::RST_WORD;
      burstCtrl_r <= txsym_pkg::RST_WORD;
      frameCtrl_r <= txsym_pkg::RST_WORD;
      cfgLow_r <= txsym_pkg::RST_WORD;
      cfgHigh_r <= txsym_pkg::RST_WORD;
    end
    else if (wrHit)
    begin
      case (regAddr)
        txsym_pkg::OFS_SYM0:
          symPat_r[0] <= regWrData & txsym_pkg::MASK_LONG_PAT;
        txsym_pkg::OFS_SYM1:
          symPat_r[1] <= regWrData & txsym_pkg::MASK_LONG_PAT;
        txsym_pkg::OFS_SYM2:
          symPat_r[2] <= regWrData & txsym_pkg::MASK_SHORT_PAT;
        txsym_pkg::OFS_SYM3:
          symPat_r[3] <= regWrData & txsym_pkg::MASK_SHORT_PAT;
        txsym_pkg::OFS_LEN_LOW:
          lenLow_r <= regWrData & txsym_pkg::MASK_LEN_LOW;
        txsym_pkg::OFS_LEN_HIGH:
          lenHigh_r <= regWrData & txsym_pkg::MASK_LEN_HIGH;
        txsym_pkg::OFS_BURST_LEN:
          burstLen_r <= regWrData;
        txsym_pkg::OFS_BURST_CTRL:
          burstCtrl_r <= regWrData & txsym_pkg::MASK_BURST_CTRL;
        txsym_pkg::OFS_FRAME_CTRL:
          frameCtrl_r <= regWrData & txsym_pkg::MASK_FRAME_CTRL;
        txsym_pkg::OFS_CFG_LOW:
          cfgLow_r <= regWrData & txsym_pkg::MASK_CFG;
        txsym_pkg::OFS_CFG_HIGH:
          cfgHigh_r <= regWrData & txsym_pkg::MASK_CFG;
        default:
          ;
      endcase
    end
  end

  // Sequencer: each step out of a burst, pattern or data is taken on the tick that sends the last bit
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_r <= txsym_pkg::ST_IDLE;
      cnt_r <= 8'h00;
      symIdx_r <= 2'h0;
      trailing_r <= 1'b0;
      haveByte_r <= 1'b0;
      dataSh_r <= 8'h00;
      bitPos_r <= 3'h0;
      lastByte_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        txsym_pkg::ST_IDLE:
          if (startReq)
          begin
            trailing_r <= 1'b0;
            haveByte_r <= 1'b0;
            if (leadSel != txsym_pkg::SEL_NONE)
            begin
              state_r <= loadState;
              cnt_r <= loadCnt;
              symIdx_r <= reqIdx;
            end
            else
              state_r <= dataState;
          end
        txsym_pkg::ST_BURST:
          if (txBitTick)
          begin
            if (cnt_r == 8'h00)
            begin
              state_r <= txsym_pkg::ST_PAT;
              cnt_r <= {4'h0, curLen};
            end
            else
              cnt_r <= 8'(cnt_r - 8'h01);
          end
        txsym_pkg::ST_PAT:
          if (txBitTick)
          begin
            if (cnt_r != 8'h00)
              cnt_r <= 8'(cnt_r - 8'h01);
            else if (trailing_r)
              state_r <= txsym_pkg::ST_IDLE;
            else
              state_r <= dataState;
          end
        txsym_pkg::ST_DATA:
          if (txBitTick)
          begin
            if (haveByte_r)
            begin
              bitPos_r <= 3'(bitPos_r + 3'h1);
              if (bitPos_r == 3'h7)
              begin
                haveByte_r <= 1'b0;
                if (lastByte_r)
                begin
                  trailing_r <= 1'b1;
                  symIdx_r <= reqIdx;
                  cnt_r <= loadCnt;
                  state_r <= (trailSel != txsym_pkg::SEL_NONE)
                             ? loadState : txsym_pkg::ST_IDLE;
                end
              end
            end
            else if (dnIf.valid)
            begin
              haveByte_r <= 1'b1;
              dataSh_r <= dnIf.data;
              bitPos_r <= 3'h1;
              lastByte_r <= dnIf.last;
            end
          end
        txsym_pkg::ST_DRAIN:
          if (dnIf.valid && dnIf.last)
          begin
            trailing_r <= 1'b1;
            symIdx_r <= reqIdx;
            cnt_r <= loadCnt;
            state_r <= (trailSel != txsym_pkg::SEL_NONE)
                       ? loadState : txsym_pkg::ST_IDLE;
          end
        default:
          state_r <= txsym_pkg::ST_IDLE;
      endcase
    end
  end

  // Bit output toward the modulator, one bit per tick
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      txBit_r <= 1'b0;
      txBitValid_r <= 1'b0;
    end
    else
    begin
      // Dropped bytes in the drain state must not reach the modulator
      txBitValid_r <= txBitTick && (inSymbol
                      || ((state_r == txsym_pkg::ST_DATA)
                          && (pop || haveByte_r)));
      if (state_r == txsym_pkg::ST_BURST)
        txBit_r <= burstVal;
      else if (state_r == txsym_pkg::ST_PAT)
        txBit_r <= patBit;
      else if (haveByte_r)
        txBit_r <= dataSh_r[bitPos_r];
      else
        txBit_r <= dnIf.data[0];
    end
  end

  // Symbol config follows the set of the symbol on air
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      txSymbolActive_r <= 1'b0;
      txCfg_r <= 12'h000;
      frameBusy_r <= 1'b0;
    end
    else
    begin
      txSymbolActive_r <= inSymbol;
      frameBusy_r <= (state_r != txsym_pkg::ST_IDLE);
      if (inSymbol)
        txCfg_r <= activeCfg;
    end
  end

  // Underrun is sticky; a new starve wins over a clearing write
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      underrun_r <= 1'b0;
    else if (starve)
      underrun_r <= 1'b1;
    else if (wrHit && (regAddr == txsym_pkg::OFS_STATUS)
             && regWrData[txsym_pkg::STAT_UNDERRUN])
      underrun_r <= 1'b0;
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      regRdData_r <= txsym_pkg::RST_WORD;
    else if (!regRdStrobe)
      regRdData_r <= txsym_pkg::RST_WORD;
    else
    begin
      case (regAddr)
        txsym_pkg::OFS_SYM0: regRdData_r <= symPat_r[0];
        txsym_pkg::OFS_SYM1: regRdData_r <= symPat_r[1];
        txsym_pkg::OFS_SYM2: regRdData_r <= symPat_r[2];
        txsym_pkg::OFS_SYM3: regRdData_r <= symPat_r[3];
        txsym_pkg::OFS_LEN_LOW: regRdData_r <= lenLow_r;
        txsym_pkg::OFS_LEN_HIGH: regRdData_r <= lenHigh_r;
        txsym_pkg::OFS_BURST_LEN: regRdData_r <= burstLen_r;
        txsym_pkg::OFS_BURST_CTRL: regRdData_r <= burstCtrl_r;
        txsym_pkg::OFS_FRAME_CTRL: regRdData_r <= frameCtrl_r;
        txsym_pkg::OFS_CFG_LOW: regRdData_r <= cfgLow_r;
        txsym_pkg::OFS_CFG_HIGH: regRdData_r <= cfgHigh_r;
        txsym_pkg::OFS_STATUS:
          regRdData_r <= {13'h0000, inSymbol, underrun_r,
                          state_r != txsym_pkg::ST_IDLE};
        default: regRdData_r <= txsym_pkg::RST_WORD;
      endcase
    end
  end

  // Outputs straight from flops
  assign regRdData = regRdData_r;
  assign txBit = txBit_r;
  assign txBitValid = txBitValid_r;
  assign txSymbolActive = txSymbolActive_r;
  assign txCfg = txCfg_r;
  assign frameBusy = frameBusy_r;

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_short_pattern: assert property (
    (symPat_r[2][15:8] == 8'h00) && (symPat_r[3][15:8] == 8'h00))
    else $error("short symbol holds bits above eight");

  chk_length_write: assert property (
    wrHit && (regAddr == txsym_pkg::OFS_LEN_HIGH)
    |=> lenHigh_r == ($past(regWrData) & txsym_pkg::MASK_LEN_HIGH))
    else $error("length write not taken");

  chk_lead_choice: assert property (
    (state_r == txsym_pkg::ST_IDLE) && startReq && (leadSel != 2'h0)
    |=> inSymbol && (symIdx_r == 2'($past(leadSel) - 2'h1)))
    else $error("wrong leading symbol");

  chk_trail_choice: assert property (
    inSymbol && trailing_r |-> symIdx_r != 2'h0)
    else $error("symbol zero sent after data");

  chk_burst_pair: assert property (
    (state_r == txsym_pkg::ST_BURST) && txBitTick
    |-> !symIdx_r[1] ##1 txBitValid && (txBit == $past(burstVal)))
    else $error("burst bit wrong");

  chk_pattern_bit: assert property (
    (state_r == txsym_pkg::ST_PAT) && txBitTick
    |=> txBitValid && (txBit == $past(patBit)))
    else $error("pattern bit wrong");

  chk_cfg_set: assert property (
    inSymbol |=> {4'h0, txCfg} == (symIdx_r[1] ? $past(cfgHigh_r)
                                               : $past(cfgLow_r)))
    else $error("symbol config set wrong");

  chk_coding_gate: assert property (
    (state_r == txsym_pkg::ST_DRAIN) && txBitTick |=> !txBitValid)
    else $error("bits sent with foreign coding type");

  chk_no_gap: assert property (
    (state_r == txsym_pkg::ST_PAT) && txBitTick && (cnt_r == 8'h00)
    && !trailing_r && (codeType == 4'h0)
    |=> state_r == txsym_pkg::ST_DATA)
    else $error("gap after leading symbol");

endmodule : tx_symbol_generator
`default_nettype wire

// File: bench/tx_modulator_model.sv
// Modulator-side model: issues bit ticks and logs each bit that arrives.
// Assumes the generator answers a tick with a one-cycle valid pulse.
`timescale 1ns/1ps
`default_nettype none
module tx_modulator_model
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Cycles between ticks, minus one; at least one
  input wire logic [3:0] tickGap,
  // From the generator
  input wire logic txBit,
  input wire logic txBitValid,
  // To the generator and the bench
  output logic txBitTick,
  output logic [63:0] bitLog,
  output logic [7:0] bitCount
);
  logic [3:0] gapCnt_r;

  // Free-running bit clock; a wide gap stands for a slow modulator
  always_ff @(posedge clock)
  begin
    if (!rst_n || gapCnt_r >= tickGap)
    begin
      gapCnt_r <= 4'h0;
      txBitTick <= rst_n;
    end
    else
    begin
      gapCnt_r <= gapCnt_r + 4'h1;
      txBitTick <= 1'b0;
    end
  end

  // Newest bit enters at the bottom, so the first bit sits highest
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      bitLog <= 64'h0;
      bitCount <= 8'h00;
    end
    else if (txBitValid)
    begin
      bitLog <= {bitLog[62:0], txBit};
      bitCount <= bitCount + 8'h01;
    end
  end
endmodule : tx_modulator_model
`default_nettype wire

// File: bench/tx_symbol_generator_tb.sv
// Bench for the transmit symbol generator: register tasks and frames.
// Assumes the design package and the modulator model beside it.
`timescale 1ns/1ps
`default_nettype none
module tx_symbol_generator_tb;
  logic clock, rst_n, regWrStrobe, regRdStrobe, dataValid, dataLast;
  logic dataReady, txBitTick, txBit, txBitValid, txSymbolActive, frameBusy;
  logic [3:0] regAddr, tickGap;
  logic [15:0] regWrData, regRdData;
  logic [7:0] dataByte, bitCount;
  logic [11:0] txCfg;
  logic [63:0] bitLog, expBits;
  logic [15:0] sh [0:15];
  int expN, nErrors, nCompared, symBits, expSym;

  tx_symbol_generator dut (.clock(clock), .rst_n(rst_n),
    .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .dataValid(dataValid), .dataByte(dataByte), .dataLast(dataLast),
    .dataReady(dataReady), .txBitTick(txBitTick), .txBit(txBit),
    .txBitValid(txBitValid), .txSymbolActive(txSymbolActive),
    .txCfg(txCfg), .frameBusy(frameBusy));
  tx_modulator_model modem (.clock(clock), .rst_n(rst_n),
    .tickGap(tickGap), .txBit(txBit), .txBitValid(txBitValid),
    .txBitTick(txBitTick), .bitLog(bitLog), .bitCount(bitCount));

  // Clock at 40 MHz
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Bits delivered while the symbol flag stands
  always @(posedge clock)
    if (txBitValid && txSymbolActive) symBits <= symBits + 1;

  // Writable bits per register; write-only and unmapped read as zero
  function automatic logic [15:0] wmask(input int a);
    case (a)
      0, 1, 6: wmask = txsym_pkg::MASK_LONG_PAT;
      2, 3: wmask = txsym_pkg::MASK_SHORT_PAT;
      4: wmask = txsym_pkg::MASK_LEN_LOW;
      5: wmask = txsym_pkg::MASK_LEN_HIGH;
      7: wmask = txsym_pkg::MASK_BURST_CTRL;
      8: wmask = txsym_pkg::MASK_FRAME_CTRL;
      9, 10: wmask = txsym_pkg::MASK_CFG;
      default: wmask = 16'h0000;
    endcase
  endfunction : wmask

  task automatic check(input string what, input logic [63:0] seen,
    input logic [63:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge clock);
    regWrStrobe <= 1'b0;
    sh[a] = d & wmask(a);
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clock);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1 check($sformatf("reg %0h", a), 64'(regRdData), 64'(e));
  endtask : rd

  // Byte is held until the buffer takes it
  task automatic push(input logic [7:0] b, input logic last);
    @(posedge clock);
    dataValid <= 1'b1;
    dataByte <= b;
    dataLast <= last;
    do @(posedge clock); while (dataReady !== 1'b1);
    dataValid <= 1'b0;
  endtask : push

  task automatic addBit(input logic b);
    expBits = {expBits[62:0], b};
    expN++;
  endtask : addBit

  // Expected bits of one symbol from the shadow registers
  task automatic addSym(input int s);
    int len;
    int n0;
    n0 = expN;
    if (s < 2 && sh[7][2 * s])
      for (int i = 0; i <= sh[6][8 * s +: 8]; i++) addBit(sh[7][2 * s + 1]);
    len = s == 0 ? sh[4][3:0] : s == 1 ? sh[4][7:4] :
      s == 2 ? sh[5][2:0] : sh[5][6:4];
    for (int i = len; i >= 0; i--) addBit(sh[s][i]);
    expSym += expN - n0;
  endtask : addSym

  task automatic waitIdle;
    int k;
    k = 0;
    while (frameBusy !== 1'b1 && k < 20) begin @(posedge clock); k++; end
    k = 0;
    while (frameBusy !== 1'b0 && k < 4000) begin @(posedge clock); k++; end
    repeat (3) @(posedge clock);
    check("frame end", 64'(frameBusy), 64'h0);
  endtask : waitIdle

  task automatic frame(input logic [7:0] fc, input logic [7:0] b0,
    input logic [7:0] b1, input logic two);
    logic [7:0] c0;
    logic hi;
    int s0;
    expBits = 64'h0;
    expN = 0;
    expSym = 0;
    wr(txsym_pkg::OFS_FRAME_CTRL, {8'h00, fc});
    if (fc[1:0] != 2'h0) addSym(fc[1:0] - 1);
    for (int i = 0; i < 8 && fc[7:4] == txsym_pkg::CODE_BITGEN; i++)
      addBit(b0[i]);
    for (int i = 0; i < 8 && two && fc[7:4] == 4'h0; i++) addBit(b1[i]);
    if (fc[3:2] != 2'h0) addSym(fc[3:2]);
    c0 = bitCount;
    s0 = symBits;
    if (two)
    begin
      push(b0, 1'b0);
      push(b1, 1'b1);
      repeat (2) @(posedge clock);
      check("buffer full", 64'(dataReady), 64'h0);
    end
    else
      push(b0, 1'b1);
    wr(txsym_pkg::OFS_CONTROL, 16'h0001);
    waitIdle();
    check("bit count", 64'(bitCount - c0), 64'(expN));
    check("bits", bitLog & ((64'h1 << expN) - 1), expBits);
    check("symbol bits", 64'(symBits - s0), 64'(expSym));
    hi = fc[3:2] != 2'h0 ? fc[3:2] > 2'h1 : fc[1:0] == 2'h3;
    if (fc[3:0] != 4'h0)
      check("config", 64'(txCfg), 64'(sh[hi ? 10 : 9][11:0]));
    $display("test frame %0h done", fc);
  endtask : frame

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // Hang guard, well beyond the longest expected run
  initial
  begin
    #(25 * 80000);
    nErrors++;
    give_verdict();
  end

  initial
  begin
    {rst_n, regWrStrobe, regRdStrobe, dataValid, dataLast} = 5'h00;
    {regAddr, regWrData, dataByte} = 28'h0;
    tickGap = 4'h1;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 0; a < 14; a++) rd(a[3:0], 16'h0000);
    $display("test reset done");
    for (int a = 0; a < 11; a++)
    begin
      wr(a[3:0], 16'hFFFF);
      rd(a[3:0], wmask(a));
    end
    wr(4'hD, 16'hFFFF);
    rd(4'hD, 16'h0000);
    $display("test registers done");
    // Patterns zero and three carry set bits above their lengths on purpose
    wr(txsym_pkg::OFS_SYM0, 16'hB3C5);
    wr(txsym_pkg::OFS_SYM1, 16'h8E71);
    wr(txsym_pkg::OFS_SYM2, 16'h0096);
    wr(txsym_pkg::OFS_SYM3, 16'h00A5);
    wr(txsym_pkg::OFS_CFG_LOW, 16'h05A3);
    wr(txsym_pkg::OFS_CFG_HIGH, 16'h0C3C);
    wr(txsym_pkg::OFS_BURST_LEN, 16'h0203);
    wr(txsym_pkg::OFS_BURST_CTRL, 16'h0009);
    wr(txsym_pkg::OFS_LEN_LOW, 16'h00F4);
    wr(txsym_pkg::OFS_LEN_HIGH, 16'h0027);
    for (int k = 0; k < 4; k++) frame(8'(k * 5), 8'hA5, 8'h00, 1'b0);
    wr(txsym_pkg::OFS_BURST_CTRL, 16'h000C);
    frame(8'h06, 8'h81, 8'h00, 1'b0);
    tickGap <= 4'h6;
    frame(8'h0E, 8'h3C, 8'hC3, 1'b1);
    tickGap <= 4'h1;
    frame(8'h1D, 8'h5A, 8'h00, 1'b0);
    // Data phase with no byte on hand
    wr(txsym_pkg::OFS_FRAME_CTRL, 16'h0000);
    wr(txsym_pkg::OFS_CONTROL, 16'h0001);
    repeat (20) @(posedge clock);
    rd(txsym_pkg::OFS_STATUS, 16'h0003);
    push(8'h3C, 1'b1);
    waitIdle();
    rd(txsym_pkg::OFS_STATUS, 16'h0002);
    wr(txsym_pkg::OFS_STATUS, 16'h0002);
    rd(txsym_pkg::OFS_STATUS, 16'h0000);
    $display("test underrun done");
    give_verdict();
  end
endmodule : tx_symbol_generator_tb
`default_nettype wire
